//--- prp_defines.vh
// constants used by the parallel port core; the fifo memory does not include them
`ifndef PRP_DEFINES_VH
`define PRP_DEFINES_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define PRP_CLK_PERIOD_NS 40
`define PRP_EPP_TIMEOUT_NS 10000

// ----------------------------------------------------------------
// host register offsets
// ----------------------------------------------------------------
`define PRP_ADDR_W 11
`define PRP_OFS_DATA 11'h000
`define PRP_OFS_STATUS 11'h001
`define PRP_OFS_CONTROL 11'h002
`define PRP_OFS_EPP_ADDR 11'h003
`define PRP_OFS_EPP_DATA_HI 9'h001
`define PRP_OFS_FIFO 11'h400
`define PRP_OFS_CFG_B 11'h401
`define PRP_OFS_EXT_CTRL 11'h402

// ----------------------------------------------------------------
// port modes held in the extended control register
// ----------------------------------------------------------------
`define PRP_MODE_STD 3'h0
`define PRP_MODE_FIFO 3'h2
`define PRP_MODE_ECP 3'h3
`define PRP_MODE_EPP 3'h4
`define PRP_MODE_TEST 3'h6
`define PRP_MODE_CFG 3'h7

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PRP_CTL_STROBE 0
`define PRP_CTL_AUTOFD 1
`define PRP_CTL_INIT 2
`define PRP_CTL_SELIN 3
`define PRP_CTL_ACKIE 4
`define PRP_CTL_DIR 5
`define PRP_CTL_MASK 8'h3F

// ----------------------------------------------------------------
// extended control fields and reset values
// ----------------------------------------------------------------
`define PRP_ECR_MODE_HI 7
`define PRP_ECR_MODE_LO 5
`define PRP_ECR_ERRIE_N 4
`define PRP_ECR_DMA_ENABLE_BIT 3
`define PRP_ECR_SERVICE 2
`define PRP_ECR_FULL 1
`define PRP_ECR_EMPTY 0
`define PRP_ECR_RESET 6'h05
`define PRP_CTL_RESET 8'h04
`define PRP_CFG_A_VALUE 8'h10
`define PRP_STS_TIMEOUT 0
`define PRP_BYTE_ZERO 8'h00
`define PRP_BYTE_ONES 8'hFF

`endif

//--- prp_fifo_mem.v
// sixteen byte storage shared by every fifo port, registered read data
`timescale 1ns/10ps
`default_nettype none

module prp_fifo_mem #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// clock and reset
	input wire clock,
	input wire nrst,
	// write side
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	// read side
	input wire [AW-1:0] rd_addr,
	output reg [WIDTH-1:0] rd_data_reg
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];

	// ----------------------------------------------------------------
	// storage, no reset so it maps onto a plain ram
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always @(posedge clock)
	begin
		if (!nrst)
			rd_data_reg <= {WIDTH{1'b0}};
		else
			rd_data_reg <= mem[rd_addr];
	end

endmodule
`default_nettype wire

//--- prp_core.v
// parallel port core: epp 1.7 read cycle, pin control, extended map
`timescale 1ns/10ps
`default_nettype none
`include "prp_defines.vh"

module prp_core #(
	parameter WORD_W = 8,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4,
	parameter TIMEOUT_CYC = `PRP_EPP_TIMEOUT_NS / `PRP_CLK_PERIOD_NS
) (
	// clock and reset
	input wire clock,
	input wire nrst,
	// host i/o cycle
	input wire [`PRP_ADDR_W-1:0] host_addr,
	input wire host_rd,
	input wire host_wr,
	input wire [WORD_W-1:0] host_wdata,
	output reg [WORD_W-1:0] host_rdata_reg,
	output reg host_done_reg,
	// chip configuration selections
	input wire [2:0] cfg_irq_sel,
	input wire [2:0] cfg_dma_sel,
	// parallel data bus
	input wire [WORD_W-1:0] port_data_bus_in,
	output reg [WORD_W-1:0] port_data_bus_out_reg,
	output reg port_data_bus_oe_reg,
	// peripheral inputs
	input wire periph_wait_n,
	input wire periph_interrupt,
	input wire busy,
	input wire ack_n,
	input wire paper_out_status,
	input wire selected_status,
	input wire fault_n,
	// peripheral outputs
	output reg write_dir_n_reg,
	output reg data_strobe_n_reg,
	output reg addr_strobe_n_reg,
	output reg periph_reset_n_reg,
	output reg irq_out_reg
);

	localparam ST_IDLE = 3'b001;
	localparam ST_RDREG = 3'b010;
	localparam ST_EPP = 3'b100;
	localparam CNT_W = 12;
	localparam [CNT_W-1:0] TIMEOUT_LIM = TIMEOUT_CYC[CNT_W-1:0];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [2:0] state_reg, state_next;
	reg [WORD_W-1:0] data_reg, data_next;
	reg [7:0] control_reg, control_next;
	reg [5:0] ext_ctrl_reg, ext_ctrl_next;
	reg timeout_reg, timeout_next;
	reg dir_eff_reg, dir_eff_next;
	reg addr_cycle_reg, addr_cycle_next;
	reg [CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
	reg [`PRP_ADDR_W-1:0] rd_addr_reg, rd_addr_next;
	reg [FIFO_AW-1:0] wr_ptr_reg, rd_ptr_reg;
	reg [FIFO_AW:0] count_reg;
	reg [WORD_W-1:0] host_rdata_next;
	reg host_done_next;
	reg dstb_next, astb_next;
	reg push, pop;

	wire [FIFO_AW-1:0] wr_ptr_inc;
	wire [FIFO_AW-1:0] rd_ptr_inc;
	wire [WORD_W-1:0] fifo_q;
	wire [2:0] mode;
	wire fifo_full;
	wire fifo_empty;
	wire epp_mode;
	wire idle;
	wire is_epp_port;
	wire [7:0] status_val;
	wire [7:0] cfg_b_val;
	wire [7:0] ecr_val;

	assign mode = ext_ctrl_reg[`PRP_ECR_MODE_HI-2:`PRP_ECR_MODE_LO-2];
	assign epp_mode = (mode == `PRP_MODE_EPP);
	assign idle = state_reg[0];
	assign fifo_full = (count_reg == FIFO_DEPTH);
	assign fifo_empty = (count_reg == 0);
	assign wr_ptr_inc = wr_ptr_reg + 1'b1;
	assign rd_ptr_inc = rd_ptr_reg + 1'b1;
	assign is_epp_port = (host_addr == `PRP_OFS_EPP_ADDR) ||
		(host_addr[`PRP_ADDR_W-1:2] == `PRP_OFS_EPP_DATA_HI);

	// status keeps the watchdog flag in its lowest bit
	assign status_val = {~busy, ack_n, paper_out_status, selected_status,
		fault_n, 2'b00, timeout_reg};
	// compression is not offered, so its bit reads zero
	assign cfg_b_val = {1'b0, periph_interrupt, cfg_irq_sel,
		cfg_dma_sel};
	assign ecr_val = {ext_ctrl_reg, fifo_full, fifo_empty};

	// ----------------------------------------------------------------
	// one fifo behind every fifo port
	// ----------------------------------------------------------------
	prp_fifo_mem #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clock(clock),
		.nrst(nrst),
		.wr_en(push),
		.wr_addr(wr_ptr_reg),
		.wr_data(host_wdata),
		.rd_addr(rd_ptr_reg),
		.rd_data_reg(fifo_q)
	);

	// ----------------------------------------------------------------
	// host cycle decode and epp read sequencer
	// ----------------------------------------------------------------
	always @*
	begin
		state_next = state_reg;
		data_next = data_reg;
		control_next = control_reg;
		ext_ctrl_next = ext_ctrl_reg;
		timeout_next = timeout_reg;
		dir_eff_next = dir_eff_reg;
		addr_cycle_next = addr_cycle_reg;
		wd_cnt_next = wd_cnt_reg;
		rd_addr_next = rd_addr_reg;
		host_rdata_next = host_rdata_reg;
		host_done_next = 1'b0;
		dstb_next = 1'b0;
		astb_next = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		case (state_reg)
		ST_IDLE:
		begin
			// direction changes only between cycles
			dir_eff_next = control_reg[`PRP_CTL_DIR];
			if (host_wr)
			begin
				host_done_next = 1'b1;
				if (host_addr == `PRP_OFS_DATA)
				begin
					// in ecp mode this offset is the address fifo port
					if (mode == `PRP_MODE_ECP)
						push = !fifo_full;
					else
						data_next = host_wdata;
				end
				else if (host_addr == `PRP_OFS_STATUS)
				begin
					if (host_wdata[`PRP_STS_TIMEOUT])
						timeout_next = 1'b0;
				end
				else if (host_addr == `PRP_OFS_CONTROL)
					control_next = host_wdata & `PRP_CTL_MASK;
				else if (epp_mode && is_epp_port)
					data_next = host_wdata;
				else if (host_addr == `PRP_OFS_FIFO)
					push = !fifo_full &&
						(mode != `PRP_MODE_CFG);
				else if (host_addr == `PRP_OFS_EXT_CTRL)
					ext_ctrl_next = host_wdata[7:2];
			end
			else if (host_rd)
			begin
				rd_addr_next = host_addr;
				if (epp_mode && is_epp_port)
				begin
					// strobe goes low on the same edge that takes the read
					addr_cycle_next = (host_addr == `PRP_OFS_EPP_ADDR);
					dstb_next = (host_addr != `PRP_OFS_EPP_ADDR);
					astb_next = (host_addr == `PRP_OFS_EPP_ADDR);
					wd_cnt_next = {CNT_W{1'b0}};
					state_next = ST_EPP;
				end
				else
				begin
					pop = (host_addr == `PRP_OFS_FIFO) && !fifo_empty &&
						(mode != `PRP_MODE_CFG);
					state_next = ST_RDREG;
				end
			end
		end
		ST_RDREG:
		begin
			host_done_next = 1'b1;
			state_next = ST_IDLE;
			case (rd_addr_reg)
			`PRP_OFS_DATA: host_rdata_next = data_reg;
			`PRP_OFS_STATUS: host_rdata_next = status_val;
			`PRP_OFS_CONTROL: host_rdata_next = control_reg;
			`PRP_OFS_FIFO:
				host_rdata_next = (mode == `PRP_MODE_CFG) ?
					`PRP_CFG_A_VALUE : fifo_q;
			`PRP_OFS_CFG_B: host_rdata_next = cfg_b_val;
			`PRP_OFS_EXT_CTRL: host_rdata_next = ecr_val;
			default: host_rdata_next = `PRP_BYTE_ONES;
			endcase
		end
		ST_EPP:
		begin
			wd_cnt_next = wd_cnt_reg + 1'b1;
			if (periph_wait_n)
			begin
				// wait released: data valid, end the cycle
				data_next = port_data_bus_in;
				host_rdata_next = port_data_bus_in;
				host_done_next = 1'b1;
				state_next = ST_IDLE;
			end
			else if (wd_cnt_reg >= TIMEOUT_LIM - 1'b1)
			begin
				// abort so the host bus is never left hung
				timeout_next = 1'b1;
				host_rdata_next = `PRP_BYTE_ONES;
				host_done_next = 1'b1;
				state_next = ST_IDLE;
			end
			else
			begin
				dstb_next = !addr_cycle_reg;
				astb_next = addr_cycle_reg;
			end
		end
		default:
			state_next = ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			state_reg <= ST_IDLE;
			data_reg <= `PRP_BYTE_ZERO;
			control_reg <= `PRP_CTL_RESET;
			ext_ctrl_reg <= `PRP_ECR_RESET;
			timeout_reg <= 1'b0;
			dir_eff_reg <= 1'b0;
			addr_cycle_reg <= 1'b0;
			wd_cnt_reg <= {CNT_W{1'b0}};
			rd_addr_reg <= {`PRP_ADDR_W{1'b0}};
			host_rdata_reg <= `PRP_BYTE_ZERO;
			host_done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			data_reg <= data_next;
			control_reg <= control_next;
			ext_ctrl_reg <= ext_ctrl_next;
			// a timeout in the clearing cycle still sets the flag
			timeout_reg <= timeout_next |
				(state_next == ST_IDLE && state_reg == ST_EPP &&
				!periph_wait_n);
			dir_eff_reg <= dir_eff_next;
			addr_cycle_reg <= addr_cycle_next;
			wd_cnt_reg <= wd_cnt_next;
			rd_addr_reg <= rd_addr_next;
			host_rdata_reg <= host_rdata_next;
			host_done_reg <= host_done_next;
		end
	end

	// ----------------------------------------------------------------
	// fifo pointers, one push or pop per host cycle
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			wr_ptr_reg <= {FIFO_AW{1'b0}};
			rd_ptr_reg <= {FIFO_AW{1'b0}};
			count_reg <= {(FIFO_AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_inc;
			if (pop)
				rd_ptr_reg <= rd_ptr_inc;
			if (push)
				count_reg <= count_reg + 1'b1;
			else if (pop)
				count_reg <= count_reg - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// pin drivers, all from flip-flops
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			port_data_bus_out_reg <= `PRP_BYTE_ZERO;
			port_data_bus_oe_reg <= 1'b0;
			write_dir_n_reg <= 1'b1;
			data_strobe_n_reg <= 1'b1;
			addr_strobe_n_reg <= 1'b1;
			periph_reset_n_reg <= 1'b0;
			irq_out_reg <= 1'b0;
		end
		else
		begin
			port_data_bus_out_reg <= data_next;
			// bus released during an epp read and while reversed
			port_data_bus_oe_reg <= !dir_eff_next &&
				(state_next != ST_EPP);
			if (epp_mode)
			begin
				// the control strobe bit or a forward direction drives the write pin low
				write_dir_n_reg <= !(control_reg[`PRP_CTL_STROBE] ||
					!dir_eff_next);
				data_strobe_n_reg <= !dstb_next;
				addr_strobe_n_reg <= !astb_next;
			end
			else
			begin
				write_dir_n_reg <= !control_reg[`PRP_CTL_STROBE];
				data_strobe_n_reg <= !control_reg[`PRP_CTL_AUTOFD];
				addr_strobe_n_reg <= !control_reg[`PRP_CTL_SELIN];
			end
			periph_reset_n_reg <= control_reg[`PRP_CTL_INIT];
			irq_out_reg <= periph_interrupt;
		end
	end

endmodule
`default_nettype wire

//--- prp_core_asserts.sv
// assertion checker for the parallel port core read cycle
`timescale 1ns/10ps
`default_nettype none

module prp_core_chk #(
	parameter TIMEOUT_CYC = 250
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// host cycle
	input wire logic host_rd,
	input wire logic [7:0] host_rdata_reg,
	input wire logic host_done_reg,
	// port pins
	input wire logic [7:0] port_data_bus_out_reg,
	input wire logic port_data_bus_oe_reg,
	input wire logic periph_wait_n,
	input wire logic periph_interrupt,
	input wire logic data_strobe_n_reg,
	input wire logic addr_strobe_n_reg,
	input wire logic irq_out_reg
);
	// a strobe low just after a read marks an epp read
	logic rd_q;
	logic cyc;
	logic [15:0] cnt;
	wire logic lo;
	wire logic ep_lo;
	assign lo = !(data_strobe_n_reg && addr_strobe_n_reg);
	assign ep_lo = (cyc || rd_q) && lo;
	default clocking dc @(posedge clock); endclocking
	default disable iff (!nrst);
	always @(posedge clock)
	begin
		if (!nrst)
		begin
			rd_q <= 1'h0;
			cyc <= 1'h0;
			cnt <= 16'h0000;
		end
		else
		begin
			rd_q <= host_rd;
			cyc <= (cyc || (rd_q && lo)) && !host_done_reg;
			cnt <= ep_lo ? cnt + 16'h0001 : 16'h0000;
		end
	end
	a_bus_released: assert property (
		ep_lo |-> !port_data_bus_oe_reg)
		else $error("bus driven under strobe");
	a_wait_stalls: assert property (
		ep_lo && !periph_wait_n && cnt < TIMEOUT_CYC - 1 |=> ep_lo)
		else $error("read ended while wait low");
	a_release_ends: assert property (
		ep_lo && periph_wait_n |=> host_done_reg && !lo)
		else $error("no final sync after wait release");
	a_timeout_bound: assert property (
		cnt <= TIMEOUT_CYC)
		else $error("stalled read not aborted");
	a_timeout_answer: assert property (
		ep_lo && !periph_wait_n ##1 host_done_reg |-> host_rdata_reg == 8'hFF)
		else $error("abort data wrong");
	a_one_strobe: assert property (
		ep_lo |-> data_strobe_n_reg != addr_strobe_n_reg)
		else $error("strobe choice wrong");
	a_data_frozen: assert property (
		ep_lo ##1 ep_lo |-> $stable(port_data_bus_out_reg))
		else $error("data output changed in cycle");
	a_irq_through: assert property (
		$past(nrst) |-> irq_out_reg == $past(periph_interrupt))
		else $error("interrupt not passed through");
endmodule

bind prp_core prp_core_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) prp_core_chk_inst (
	.clock, .nrst, .host_rd, .host_rdata_reg, .host_done_reg,
	.port_data_bus_out_reg, .port_data_bus_oe_reg, .periph_wait_n,
	.periph_interrupt, .data_strobe_n_reg, .addr_strobe_n_reg, .irq_out_reg
);
`default_nettype wire

//--- prp_periph_model.sv
// behavioural epp peripheral answering read cycles
`timescale 1ns/10ps
`default_nettype none

module prp_periph_model (
	// clock
	input wire logic clock,
	// core pins
	input wire logic data_strobe_n,
	input wire logic addr_strobe_n,
	input wire logic [7:0] core_out,
	input wire logic core_oe,
	// scenario controls
	input wire logic [3:0] delay,
	input wire logic hang,
	input wire logic [7:0] rd_byte,
	// lines seen by the core
	output logic [7:0] bus,
	output logic wait_n
);
	logic [3:0] cnt = 4'h0;
	logic drive = 1'h0;
	logic [7:0] last = 8'h00;
	initial wait_n = 1'h0;
	// released bus shows the inverse, so a stale copy never passes
	assign bus = core_oe ? core_out : (drive ? rd_byte : ~last);
	always @(posedge clock)
	begin
		last <= bus;
		if (data_strobe_n && addr_strobe_n)
		begin
			cnt <= 4'h0;
			drive <= 1'h0;
			wait_n <= 1'h0;
		end
		else
		begin
			cnt <= cnt + 4'h1;
			drive <= (cnt >= delay);
			wait_n <= drive && !hang;
		end
	end
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the parallel port core
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic clock, nrst, host_rd, host_wr, hang, sd, sa;
	logic busy, ack_n, paper_out_status, selected_status, fault_n;
	logic periph_interrupt;
	logic [10:0] host_addr;
	logic [7:0] host_wdata, bt, r, i;
	logic [3:0] dly;
	logic [2:0] cfg_irq_sel, cfg_dma_sel;
	wire logic [7:0] host_rdata_reg, port_data_bus_in, port_data_bus_out_reg;
	wire logic host_done_reg, port_data_bus_oe_reg, periph_wait_n;
	wire logic write_dir_n_reg, data_strobe_n_reg, addr_strobe_n_reg;
	wire logic periph_reset_n_reg, irq_out_reg;
	integer fail_count = 0;
	integer compares = 0;

	prp_core #(.TIMEOUT_CYC(16)) prp_core_inst (
		.clock, .nrst, .host_addr, .host_rd, .host_wr, .host_wdata,
		.host_rdata_reg, .host_done_reg, .cfg_irq_sel, .cfg_dma_sel,
		.port_data_bus_in, .port_data_bus_out_reg, .port_data_bus_oe_reg,
		.periph_wait_n, .periph_interrupt, .busy, .ack_n,
		.paper_out_status, .selected_status, .fault_n, .write_dir_n_reg,
		.data_strobe_n_reg, .addr_strobe_n_reg, .periph_reset_n_reg,
		.irq_out_reg
	);
	prp_periph_model prp_periph_model_inst (
		.clock, .data_strobe_n(data_strobe_n_reg),
		.addr_strobe_n(addr_strobe_n_reg), .core_out(port_data_bus_out_reg),
		.core_oe(port_data_bus_oe_reg), .delay(dly), .hang, .rd_byte(bt),
		.bus(port_data_bus_in), .wait_n(periph_wait_n)
	);

	initial
	begin
		clock = 1'h0;
		forever #20 clock = ~clock;
	end

	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		begin
			compares = compares + 1;
			if (g !== e)
			begin
				fail_count = fail_count + 1;
				$display("unexpected %s: expected %h, seen %h", s, e, g);
			end
		end
	endtask

	// one host cycle; done is awaited under a bound
	task xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
		integer n;
		begin
			@(posedge clock);
			host_addr <= a;
			host_wdata <= d;
			host_wr <= w;
			host_rd <= !w;
			@(posedge clock);
			host_wr <= 1'h0;
			host_rd <= 1'h0;
			n = 0;
			sd = 1'h0;
			sa = 1'h0;
			#1;
			while (host_done_reg !== 1'h1 && n < 100)
			begin
				sd = sd | !data_strobe_n_reg;
				sa = sa | !addr_strobe_n_reg;
				@(posedge clock);
				#1;
				n = n + 1;
			end
			r = host_rdata_reg;
			chk("done", 8'h01, {7'h00, host_done_reg});
		end
	endtask

	task wr(input logic [10:0] a, input logic [7:0] d);
		xfer(1'h1, a, d);
	endtask

	task rd(input logic [10:0] a);
		xfer(1'h0, a, 8'h00);
	endtask

	task settle;
		begin
			@(posedge clock);
			#1;
		end
	endtask

	task t_regs;
		logic [4:0] p;
		begin
			rd(11'h002);
			chk("control", 8'h04, r);
			chk("reset_n", 8'h01, {7'h00, periph_reset_n_reg});
			wr(11'h002, 8'h00);
			settle;
			chk("reset_n", 8'h00, {7'h00, periph_reset_n_reg});
			rd(11'h402);
			chk("ecr", 8'h15, r);
			// one pin high per pass, so every field is seen at both levels
			for (p = 5'h01; p != 5'h00; p = {p[3:0], 1'h0})
			begin
				@(posedge clock);
				{busy, ack_n, paper_out_status, selected_status, fault_n} <= p;
				cfg_irq_sel <= p[2:0];
				cfg_dma_sel <= p[4:2];
				periph_interrupt <= p[0];
				rd(11'h001);
				chk("status", {~p[4], p[3:0], 3'h0}, r);
				rd(11'h401);
				chk("cfg_b", {1'h0, p[0], p[2:0], p[4:2]}, r);
				chk("irq_out", {7'h00, p[0]}, {7'h00, irq_out_reg});
			end
			rd(11'h010);
			chk("unmapped", 8'hFF, r);
		end
	endtask

	task t_epp;
		begin
			wr(11'h000, 8'hA5);
			chk("data_out", 8'hA5, port_data_bus_out_reg);
			chk("bus_drv", 8'h01, {7'h00, port_data_bus_oe_reg});
			wr(11'h402, 8'h94);
			rd(11'h000);
			chk("data_epp", 8'hA5, r);
			wr(11'h002, 8'h24);
			settle;
			chk("bus_oe", 8'h00, {7'h00, port_data_bus_oe_reg});
			chk("write_hi", 8'h01, {7'h00, write_dir_n_reg});
			for (i = 8'h03; i < 8'h08; i = i + 8'h01)
			begin
				dly <= i[3:0] - 4'h3;
				bt <= 8'h30 | i;
				rd({3'h0, i});
				chk("epp_byte", 8'h30 | i, r);
				chk("dstb", {7'h00, i != 8'h03}, {7'h00, sd});
				chk("astb", {7'h00, i == 8'h03}, {7'h00, sa});
				rd(11'h000);
				chk("shared", 8'h30 | i, r);
			end
			wr(11'h002, 8'h25);
			settle;
			chk("write_n", 8'h00, {7'h00, write_dir_n_reg});
			wr(11'h002, 8'h24);
		end
	endtask

	task t_tmo;
		begin
			hang <= 1'h1;
			rd(11'h004);
			chk("abort", 8'hFF, r);
			hang <= 1'h0;
			rd(11'h001);
			chk("tmo", 8'h01, r & 8'h01);
			wr(11'h001, 8'h01);
			rd(11'h001);
			chk("tmo_clr", 8'h00, r & 8'h01);
		end
	endtask

	task t_fifo;
		begin
			wr(11'h002, 8'h04);
			wr(11'h402, 8'h10);
			wr(11'h402, 8'h50);
			for (i = 8'h00; i < 8'h10; i = i + 8'h01)
				wr(11'h400, 8'hA0 | i);
			rd(11'h402);
			chk("full", 8'h02, r & 8'h03);
			wr(11'h402, 8'hD0);
			for (i = 8'h00; i < 8'h10; i = i + 8'h01)
			begin
				rd(11'h400);
				chk("fifo", 8'hA0 | i, r);
			end
			rd(11'h402);
			chk("empty", 8'h01, r & 8'h03);
			wr(11'h402, 8'hF0);
			rd(11'h400);
			chk("cfg_a", 8'h10, r);
		end
	endtask

	task results;
		begin
			if (fail_count == 0 && compares > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask

	initial
	begin
		{nrst, host_rd, host_wr, hang, periph_interrupt} = 5'h00;
		{busy, ack_n, paper_out_status, selected_status, fault_n} = 5'h00;
		{cfg_irq_sel, cfg_dma_sel, dly} = 10'h000;
		{host_addr, host_wdata, bt} = 27'h000_0000;
		repeat (20) @(posedge clock);
		nrst <= 1'h1;
		t_regs;
		t_epp;
		t_tmo;
		t_fifo;
		results;
	end

	initial
	begin
		#200000;
		fail_count = fail_count + 1;
		results;
	end
endmodule
`default_nettype wire
